/* design/lfs_pkg.sv */
// Package of constants and carrier types for the LNB fault status block
package lfs_pkg;

  // ==========================================================
  // Status bit positions
  localparam int unsigned DIS_BIT   = 0;
  localparam int unsigned PUMP_BIT  = 1;
  localparam int unsigned OC_BIT    = 2;
  localparam int unsigned TRIM_BIT  = 3;
  localparam int unsigned LVL_BIT   = 4;
  localparam int unsigned UNUSED_BIT = 5;
  localparam int unsigned OT_BIT    = 6;
  localparam int unsigned UV_BIT    = 7;

  // ==========================================================
  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h81;

  // ==========================================================
  // Timing: overcurrent hold time and its cycle count at mclk
  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned OC_HOLD_TIME_MS   = 45;
  localparam longint unsigned OC_HOLD_CYCLES_L =
    (longint'(OC_HOLD_TIME_MS) * CLK_HZ) / 1000;
  localparam logic [31:0] OC_HOLD_CYCLES = OC_HOLD_CYCLES_L[31:0];

  // ==========================================================
  // Live sensed conditions from the analog side
  typedef struct packed {
    logic main_input_supply_low;
    logic internal_regulated_supply_low;
    logic over_threshold;
    logic overtemp;
    logic pump_above_boost_margin;
    logic level_out_wide;
    logic level_in_narrow;
    logic trim_locked;
  } lfs_sense_type;

  // ==========================================================
  // Read-side events from the serial port
  typedef struct packed {
    logic byte_loaded;
    logic byte_acked;
    logic read_abort;
  } lfs_read_type;

endpackage

/* design/lfs_sticky_bit.sv */
// Sticky fault flag with read-qualified release
`timescale 1ns/1ps
module lfs_sticky_bit (
  // Clocking
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  // Control
  input  wire logic rst_value,
  input  wire logic raise,
  input  wire logic release_ok,
  // State
  output logic      flag
);

  // ==========================================================
  // Set wins over release; release only when fault is gone
  always_ff @(posedge mclk) begin
    if (rst) begin
      flag <= rst_value; // Per-instance power-up level
    end else if (ce) begin
      if (raise) begin
        flag <= 1'b1;
      end else if (release_ok) begin
        flag <= 1'b0;
      end
    end
  end

endmodule

/* design/lfs_status.sv */
// Fault status register, latches, interrupt and output gate
`timescale 1ns/1ps
module lfs_status (
  // Clocking
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                ce,
  // Sensed conditions
  input  wire lfs_pkg::lfs_sense_type sense,
  // Control register enable bit
  input  wire logic                output_on_control,
  // Serial read events
  input  wire lfs_pkg::lfs_read_type rd,
  // Status byte and outputs
  output logic [7:0]               fault_status,
  output logic                     output_enable,
  output logic                     irq_n_o,
  output logic                     irq_n_oe
);

  // ==========================================================
  // Internal state
  logic        supply_low_fault;     // Latched undervoltage
  logic        overcurrent_fault;    // Latched overcurrent
  logic        overtemp_fault;       // Latched overtemperature
  logic        output_disabled_flag; // Registered disable, recomputed every cycle
  logic        output_level_bad;     // Hysteretic level flag
  logic        trim_lock_flag;       // Latched trim lock
  logic        irq_pending;          // Interrupt held low
  logic        read_armed;           // Byte on the wire, not yet acked
  logic [31:0] oc_count;             // Overcurrent persistence
  logic        oc_trip;              // Hold time exceeded
  logic        good_read;            // Acked full byte
  logic        uv_now;
  logic        pump_voltage_good;

  assign uv_now = sense.main_input_supply_low
                | sense.internal_regulated_supply_low;
  assign pump_voltage_good = sense.pump_above_boost_margin;
  assign good_read = read_armed & rd.byte_acked;

  // ==========================================================
  // Read tracking: byte loaded then acked; abort drops it
  always_ff @(posedge mclk) begin
    if (rst) begin
      read_armed <= 1'b0;
    end else if (ce) begin
      if (rd.byte_loaded) begin
        read_armed <= 1'b1;
      end else if (rd.read_abort | rd.byte_acked) begin
        read_armed <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Overcurrent persistence counter
  always_ff @(posedge mclk) begin
    if (rst) begin
      oc_count <= 32'h0;
    end else if (ce) begin
      if (!sense.over_threshold | !output_enable) begin
        oc_count <= 32'h0;
      end else if (oc_count <= lfs_pkg::OC_HOLD_CYCLES) begin
        oc_count <= oc_count + 32'h1;
      end
    end
  end
  assign oc_trip = oc_count > lfs_pkg::OC_HOLD_CYCLES;

  // ==========================================================
  // Latched fault bits
  lfs_sticky_bit u_uv (
    .mclk       (mclk),
    .rst        (rst),
    .ce         (ce),
    .rst_value  (1'b1),
    .raise      (uv_now),
    .release_ok (good_read & ~uv_now),
    .flag       (supply_low_fault)
  );
  lfs_sticky_bit u_oc (
    .mclk       (mclk),
    .rst        (rst),
    .ce         (ce),
    .rst_value  (1'b0),
    .raise      (oc_trip),
    .release_ok (good_read & ~sense.over_threshold),
    .flag       (overcurrent_fault)
  );
  lfs_sticky_bit u_ot (
    .mclk       (mclk),
    .rst        (rst),
    .ce         (ce),
    .rst_value  (1'b0),
    .raise      (sense.overtemp),
    .release_ok (good_read & ~sense.overtemp),
    .flag       (overtemp_fault)
  );

  // ==========================================================
  // Output gate: enable ignored while latched faults stand
  assign output_enable = output_on_control & ~supply_low_fault
                       & ~overcurrent_fault & ~overtemp_fault
                       & pump_voltage_good & ~uv_now;

  // ==========================================================
  // Output-disabled flag, registered and recomputed every cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      output_disabled_flag <= 1'b1;
    end else if (ce) begin
      if (uv_now | supply_low_fault | oc_trip | overcurrent_fault
          | sense.overtemp | overtemp_fault | ~pump_voltage_good
          | ~output_on_control) begin
        output_disabled_flag <= 1'b1;
      end else begin
        output_disabled_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Output level flag with hysteresis, only while enabled
  always_ff @(posedge mclk) begin
    if (rst) begin
      output_level_bad <= 1'b0;
    end else if (ce) begin
      if (output_enable) begin
        if (sense.level_out_wide) begin
          output_level_bad <= 1'b1;
        end else if (sense.level_in_narrow) begin
          output_level_bad <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Trim lock latch, never released
  always_ff @(posedge mclk) begin
    if (rst) begin
      trim_lock_flag <= 1'b0;
    end else if (ce) begin
      if (sense.trim_locked) begin
        trim_lock_flag <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Interrupt: only latching faults; released on acked read
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_pending <= 1'b1;
    end else if (ce) begin
      if (uv_now | oc_trip | sense.overtemp) begin
        irq_pending <= 1'b1;
      end else if (good_read) begin
        irq_pending <= 1'b0;
      end
    end
  end
  assign irq_n_o  = 1'b0;
  assign irq_n_oe = irq_pending;

  // ==========================================================
  // Status byte assembly
  always_comb begin
    fault_status = 8'h00;
    fault_status[lfs_pkg::DIS_BIT]  = output_disabled_flag;
    fault_status[lfs_pkg::PUMP_BIT] = pump_voltage_good;
    fault_status[lfs_pkg::OC_BIT]   = overcurrent_fault;
    fault_status[lfs_pkg::TRIM_BIT] = trim_lock_flag;
    fault_status[lfs_pkg::LVL_BIT]  = output_level_bad;
    fault_status[lfs_pkg::UNUSED_BIT] = 1'b0;
    fault_status[lfs_pkg::OT_BIT]   = overtemp_fault;
    fault_status[lfs_pkg::UV_BIT]   = supply_low_fault;
  end

endmodule

/* tb/lfs_status_monitor.sv */
// Concurrent checks on the fault status block ports
`timescale 1ns/1ps
module lfs_status_monitor (
  // Clocking
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic                   ce,
  // Inputs
  input wire lfs_pkg::lfs_sense_type sense,
  input wire logic                   output_on_control,
  input wire lfs_pkg::lfs_read_type  rd,
  // Outputs
  input wire logic [7:0]             fault_status,
  input wire logic                   output_enable,
  input wire logic                   irq_n_o,
  input wire logic                   irq_n_oe
);
  // ==========================================================
  // Port relations, frozen while the clock enable is low
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || !ce);
  property p_unused; fault_status[5] == 1'b0; endproperty
  a_unused: assert property (p_unused) else $error("Bit 5 set");
  property p_pump;
    fault_status[1] == sense.pump_above_boost_margin;
  endproperty
  a_pump: assert property (p_pump) else $error("Pump bit not live");
  property p_uv;
    sense.main_input_supply_low || sense.internal_regulated_supply_low
    |=> fault_status[7] && fault_status[0];
  endproperty
  a_uv: assert property (p_uv) else $error("Undervoltage missed");
  property p_ot; sense.overtemp
    |=> fault_status[6] && fault_status[0] && irq_n_oe; endproperty
  a_ot: assert property (p_ot) else $error("Overtemp missed");
  property p_pdis;
    !sense.pump_above_boost_margin |=> fault_status[0];
  endproperty
  a_pdis: assert property (p_pdis) else $error("Pump fault kept on");
  property p_oe; output_enable |-> output_on_control; endproperty
  a_oe: assert property (p_oe) else $error("Output on while off");
  property p_rel; $fell(irq_n_oe) |-> $past(rd.byte_acked); endproperty
  a_rel: assert property (p_rel) else $error("Irq freed early");
  property p_latch; $fell(fault_status[7]) || $fell(fault_status[6])
    |-> $past(rd.byte_acked); endproperty
  a_latch: assert property (p_latch) else $error("Fault freed early");
  property p_noirq; $rose(irq_n_oe) |-> $past(sense.main_input_supply_low ||
    sense.internal_regulated_supply_low || sense.overtemp ||
    sense.over_threshold); endproperty
  a_noirq: assert property (p_noirq) else $error("Stray irq");
endmodule
bind lfs_status lfs_status_monitor u_mon (.mclk(mclk), .rst(rst), .ce(ce),
  .sense(sense), .output_on_control(output_on_control), .rd(rd),
  .fault_status(fault_status), .output_enable(output_enable),
  .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));

/* tb/lfs_host.sv */
// Host controller model issuing status byte reads
`timescale 1ns/1ps
module lfs_host (
  // Clocking
  input  wire logic             mclk,
  // Read events toward the status block
  output lfs_pkg::lfs_read_type rd
);
  initial rd = 3'h0;
  // One read: byte captured, then ACK or abort, one cycle each
  task automatic read(input logic ack);
    @(posedge mclk) #1 rd = 3'h4;
    @(posedge mclk) #1 rd = ack ? 3'h2 : 3'h1;
    @(posedge mclk) #1 rd = 3'h0;
  endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the fault status block
`timescale 1ns/1ps
module tb;
  logic                   mclk = 1'b0; // 10 MHz clock
  logic                   rst  = 1'b1; // Sync reset
  logic                   en   = 1'b0; // Output on control
  logic                   ce   = 1'b1; // Clock enable
  lfs_pkg::lfs_sense_type sn;          // Sensed conditions
  lfs_pkg::lfs_read_type  rd;          // Host read events
  logic [7:0]             fault_status;
  logic                   output_enable, irq_n_o, irq_n_oe;
  int n_errors = 0, cmp_count = 0, seed = 43730, r;
  int m_uv = 0, m_ot = 0, m_tr = 0, m_lv = 0, m_irq = 1; // Model state
  always #50 mclk = ~mclk;
  lfs_status DUT (.mclk(mclk), .rst(rst), .ce(ce), .sense(sn),
    .output_on_control(en), .rd(rd), .fault_status(fault_status),
    .output_enable(output_enable), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
  lfs_host host (.mclk(mclk), .rd(rd));
  // ==========================================================
  // Compare and report
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  // Let inputs settle, then compare with the model
  task automatic settle();
    logic [7:0] x;
    repeat (3) @(posedge mclk);
    #1;
    x = {m_uv[0], m_ot[0], 1'b0, m_lv[0], m_tr[0], 1'b0,
         sn.pump_above_boost_margin, 1'b0};
    x[0] = x[7] | x[6] | !x[1] | !en;
    chk(fault_status, x);
    chk({6'h0, irq_n_o, irq_n_oe}, {7'h0, m_irq[0]});
    chk({7'h0, output_enable}, {7'h0, !x[0]});
  endtask
  // Apply sensed conditions and the enable bit
  task automatic put(input logic [7:0] s, input logic e);
    @(posedge mclk) #1;
    sn = s;
    en = e;
    m_uv |= s[7] | s[6];
    m_ot |= s[4];
    m_tr |= s[0];
    m_irq |= s[7] | s[6] | s[4];
    // Level flag only moves while the output is really on
    if (e & s[3] & !(m_uv | m_ot)) begin
      if (s[2]) m_lv = 1;
      else if (s[1]) m_lv = 0;
    end
    settle();
  endtask
  // Status read; only a full acknowledged one releases latches
  task automatic rdx(input logic ack);
    host.read(ack);
    if (ack) begin
      m_uv = sn.main_input_supply_low | sn.internal_regulated_supply_low;
      m_ot = sn.overtemp;
      m_irq = m_uv | m_ot;
    end
    settle();
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    sn = 8'h8a;
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    put(8'h8a, 1'b0);
    put(8'h0a, 1'b0);
    rdx(1'b0);
    rdx(1'b1);
    put(8'h0a, 1'b1);
    put(8'h4a, 1'b1);
    put(8'h0a, 1'b1);
    rdx(1'b1);
    put(8'h1a, 1'b1);
    put(8'h0a, 1'b1);
    rdx(1'b1);
    put(8'h02, 1'b1);
    put(8'h0a, 1'b1);
    put(8'h0b, 1'b1);
    put(8'h0a, 1'b1);
    // Random level swings and short overcurrent bursts
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      put({2'b00, r[3], 2'b01, r[1], !r[1] & r[2], 1'b0}, 1'b1);
    end
    rdx(1'b1);
    // Clock enable low: an undervoltage must not be latched
    @(posedge mclk) #1;
    ce = 1'b0;
    sn = 8'h8a;
    repeat (3) @(posedge mclk);
    #1;
    chk({7'h0, fault_status[7]}, {7'h0, m_uv[0]});
    chk({7'h0, irq_n_oe}, {7'h0, m_irq[0]});
    sn = 8'h0a;
    ce = 1'b1;
    settle();
    put(8'h0a, 1'b0);
    end_of_test();
  end
  // Watchdog, far beyond the roughly 150 cycles the tests take
  initial begin
    #1000000;
    n_errors++;
    end_of_test();
  end
endmodule
